// >>> asrc_pkg.sv
// Operation
// - write starts with all strobes active, ends when either strobe rises; the code keeps output enable high through a write
// - data setup and hold are measured from the edge ending the write
// - write enable stays high through every read cycle
// - address is valid before or with the falling chip select of a read
// - address stable at least 15 or 25 ns before write end
// - address may change 0 ns after write end
// - write data valid at least 12 or 20 ns before write end
// - write data may be released 0 ns after write end
// - chip select held high before supply leaves operating level for retention
package asrc_pkg;

    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam int CLK_PERIOD_PS = 25000;

    // timing figures in ns for the faster grade
    localparam int T_CYCLE_NS      = 25;
    localparam int T_ACCESS_NS     = 25;
    localparam int T_ADDR_SETUP_NS = 15;
    localparam int T_DATA_SETUP_NS = 12;
    localparam int T_FLOAT_WE_NS   = 8;
    localparam int T_WE_PULSE_NS   = 15;

    // least times round up, never below one cycle
    function automatic int min_cycles(input int ns);
        int c;
        c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int CYC_CYCLE  = min_cycles(T_CYCLE_NS);
    localparam int CYC_ACCESS = min_cycles(T_ACCESS_NS) + 1;
    localparam int CYC_AW     = min_cycles(T_ADDR_SETUP_NS);
    localparam int CYC_DS     = min_cycles(T_DATA_SETUP_NS);
    localparam int CYC_FLOAT  = min_cycles(T_FLOAT_WE_NS);
    localparam int CYC_PWE    = min_cycles(T_WE_PULSE_NS);
    localparam int CNT_W      = 4;
    // three synchroniser flops plus the agreement flop stand between pin and capture
    localparam int CYC_SYNC     = 4;
    localparam int CYC_RD_WAIT  = CYC_ACCESS + CYC_SYNC;
    // write count value at which data drive starts, leaving the setup span before the end
    localparam int CYC_DRIVE_AT = CYC_DS + 1;

    // write pulse spans the float wait plus the data setup, and covers the address setup
    localparam int CYC_WE_LOW_RAW = CYC_FLOAT + CYC_DS;
    localparam int CYC_WE_LOW_A = (CYC_WE_LOW_RAW > CYC_AW) ? CYC_WE_LOW_RAW : CYC_AW;
    localparam int CYC_WE_LOW = (CYC_WE_LOW_A > CYC_PWE) ? CYC_WE_LOW_A : CYC_PWE;

    typedef enum logic [1:0] {
        ASRC_CMD_READ,
        ASRC_CMD_WRITE,
        ASRC_CMD_SLEEP
    } asrc_cmd_t;

    typedef struct packed {
        asrc_cmd_t           cmd;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   wdata;
    } asrc_req_t;

    // memory pin group, strobes active low
    typedef struct packed {
        logic                cs_n;
        logic                we_n;
        logic                oe_n;
        logic [ADDR_W-1:0]   addr;
    } asrc_pins_t;

    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ONE  = 4'h1;

endpackage

// >>> asrc_sync.sv
`timescale 1ns/1ps
`default_nettype none
// three-stage pin synchroniser; output changes when stages two and three agree
module asrc_sync #(
    parameter int W = 8
) (
    input  wire logic         i_clk_sys,  // system clock
    input  wire logic         i_rstn,     // synchronous-released reset, active low
    input  wire logic [W-1:0] i_d,        // asynchronous pin levels
    output logic      [W-1:0] o_q         // filtered level
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    // first stage feeds only the second
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
        end else begin
            s1 <= i_d;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // accept a bit only once two samples agree
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            o_q <= '0;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (s2[i] == s3[i]) begin
                    o_q[i] <= s3[i];
                end
            end
        end
    end
endmodule
`default_nettype wire

// >>> asrc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module asrc_ctrl (
    input  wire logic                       i_clk_sys,  // 40 MHz system clock
    input  wire logic                       i_rstn,     // async reset, active low
    input  wire logic                       i_req_valid,// request strobe
    input  wire asrc_pkg::asrc_req_t        i_req,      // command, address, write data
    input  wire logic                       i_wake,     // leave retention standby
    input  wire logic [asrc_pkg::DATA_W-1:0] i_dq,      // data pins as seen
    output logic                            o_req_ready,// idle, may take a request
    output logic                            o_rd_valid, // read data pulse
    output logic [asrc_pkg::DATA_W-1:0]     o_rd_data,  // captured read byte
    output logic                            o_sleeping, // memory held deselected
    output asrc_pkg::asrc_pins_t            o_pins,     // strobes and address
    output logic [asrc_pkg::DATA_W-1:0]     o_dq,       // data pin drive value
    output logic                            o_dq_oe_n   // low while driving data
);
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_READ,
        ST_WRITE,
        ST_RECOVER,
        ST_SLEEP
    } asrc_state_t;

    asrc_state_t                  state;
    logic                         rstn_m;
    logic                         rstn_s;
    logic [asrc_pkg::CNT_W-1:0]   cnt;
    logic [asrc_pkg::DATA_W-1:0]  dq_sync;
    logic                         take;

    // reset released through two flops so every process leaves reset together
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            rstn_m <= 1'b0;
            rstn_s <= 1'b0;
        end else begin
            rstn_m <= 1'b1;
            rstn_s <= rstn_m;
        end
    end

    // taken only in idle with ready shown, so a request held early cannot slip in
    assign take = (state == ST_IDLE) && i_req_valid && o_req_ready;

    asrc_sync #(
        .W (asrc_pkg::DATA_W)
    ) u_dq_sync (
        .i_clk_sys (i_clk_sys),
        .i_rstn    (rstn_s),
        .i_d       (i_dq),
        .o_q       (dq_sync)
    );

    // sequencer; one cycle per state step, count down for timed phases
    always_ff @(posedge i_clk_sys or negedge rstn_s) begin
        if (!rstn_s) begin
            state <= ST_IDLE;
            cnt   <= asrc_pkg::CNT_ZERO;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (take) begin
                        if (i_req.cmd == asrc_pkg::ASRC_CMD_READ) begin
                            state <= ST_READ;
                            cnt   <= 4'(asrc_pkg::CYC_RD_WAIT);
                        end else if (i_req.cmd == asrc_pkg::ASRC_CMD_WRITE) begin
                            state <= ST_WRITE;
                            cnt   <= 4'(asrc_pkg::CYC_WE_LOW);
                        end else begin
                            state <= ST_SLEEP;
                        end
                    end
                end
                ST_READ: begin
                    // wait covers the access time plus the pin synchroniser
                    if (cnt == asrc_pkg::CNT_ONE) begin
                        state <= ST_RECOVER;
                        cnt   <= 4'(asrc_pkg::CYC_CYCLE);
                    end else begin
                        cnt <= cnt - asrc_pkg::CNT_ONE;
                    end
                end
                ST_WRITE: begin
                    if (cnt == asrc_pkg::CNT_ONE) begin
                        state <= ST_RECOVER;
                        cnt   <= 4'(asrc_pkg::CYC_CYCLE);
                    end else begin
                        cnt <= cnt - asrc_pkg::CNT_ONE;
                    end
                end
                ST_RECOVER: begin
                    // deselected gap keeps back-to-back cycles apart
                    if (cnt == asrc_pkg::CNT_ONE) begin
                        state <= ST_IDLE;
                    end else begin
                        cnt <= cnt - asrc_pkg::CNT_ONE;
                    end
                end
                ST_SLEEP: begin
                    if (i_wake) begin
                        state <= ST_RECOVER; // recovery of one read cycle
                        cnt   <= 4'(asrc_pkg::CYC_CYCLE);
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // strobes and address; address latched when idle, held through the cycle
    always_ff @(posedge i_clk_sys or negedge rstn_s) begin
        if (!rstn_s) begin
            o_pins <= '{cs_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: '0};
        end else begin
            if (take && i_req.cmd != asrc_pkg::ASRC_CMD_SLEEP) begin
                o_pins.addr <= i_req.addr;
                o_pins.cs_n <= 1'b0;
                o_pins.we_n <= (i_req.cmd == asrc_pkg::ASRC_CMD_READ);
                o_pins.oe_n <= (i_req.cmd != asrc_pkg::ASRC_CMD_READ);
            end else if ((state == ST_READ || state == ST_WRITE) && cnt == asrc_pkg::CNT_ONE) begin
                // both strobes rise together; that edge ends the write
                o_pins.cs_n <= 1'b1;
                o_pins.we_n <= 1'b1;
                o_pins.oe_n <= 1'b1;
            end
        end
    end

    // data drive; starts only after the memory has floated, ends with the write edge
    always_ff @(posedge i_clk_sys or negedge rstn_s) begin
        if (!rstn_s) begin
            o_dq      <= '0;
            o_dq_oe_n <= 1'b1;
        end else begin
            if (take && i_req.cmd == asrc_pkg::ASRC_CMD_WRITE) begin
                o_dq <= i_req.wdata;
            end
            if (state == ST_WRITE && cnt == 4'(asrc_pkg::CYC_DRIVE_AT)) begin
                o_dq_oe_n <= 1'b0;
            end else if (state == ST_WRITE && cnt == asrc_pkg::CNT_ONE) begin
                o_dq_oe_n <= 1'b1;
            end
        end
    end

    // read capture once access delay and synchroniser have passed
    always_ff @(posedge i_clk_sys or negedge rstn_s) begin
        if (!rstn_s) begin
            o_rd_valid <= 1'b0;
            o_rd_data  <= '0;
        end else begin
            o_rd_valid <= 1'b0;
            if (state == ST_READ && cnt == asrc_pkg::CNT_ONE) begin
                o_rd_valid <= 1'b1;
                o_rd_data  <= dq_sync;
            end
        end
    end

    // status flags registered from the next state
    always_ff @(posedge i_clk_sys or negedge rstn_s) begin
        if (!rstn_s) begin
            o_req_ready <= 1'b0;
            o_sleeping  <= 1'b0;
        end else begin
            o_req_ready <= (state == ST_IDLE && !take) ||
                           (state == ST_RECOVER && cnt == asrc_pkg::CNT_ONE);
            o_sleeping  <= (state == ST_SLEEP && !i_wake) ||
                           (take && i_req.cmd == asrc_pkg::ASRC_CMD_SLEEP);
        end
    end

    sequence write_start_s;
        $fell(o_pins.we_n) && !o_pins.cs_n;
    endsequence

    property no_early_drive_p;
        @(posedge i_clk_sys) disable iff (!rstn_s)
        write_start_s |-> o_dq_oe_n;
    endproperty

    float_wait_a: assert property (no_early_drive_p)
        else $error("data driven before memory float time");

    drive_release_a: assert property (@(posedge i_clk_sys) disable iff (!rstn_s)
        $rose(o_pins.we_n) |-> o_dq_oe_n)
        else $error("data still driven after write end");

    read_we_high_a: assert property (@(posedge i_clk_sys) disable iff (!rstn_s)
        (!o_pins.oe_n && !o_pins.cs_n) |-> o_pins.we_n)
        else $error("write enable low during read");

    addr_stable_a: assert property (@(posedge i_clk_sys) disable iff (!rstn_s)
        (!o_pins.cs_n && !$rose(o_pins.cs_n) && !$fell(o_pins.cs_n))
        |-> $stable(o_pins.addr))
        else $error("address moved inside a cycle");

    data_setup_a: assert property (@(posedge i_clk_sys) disable iff (!rstn_s)
        $rose(o_pins.we_n) |-> !$past(o_dq_oe_n) && $stable(o_dq))
        else $error("write data not set up before write end");

    write_pair_a: assert property (@(posedge i_clk_sys) disable iff (!rstn_s)
        !o_pins.we_n |-> !o_pins.cs_n)
        else $error("write enable low without chip select");

    sleep_desel_a: assert property (@(posedge i_clk_sys) disable iff (!rstn_s)
        o_sleeping |-> o_pins.cs_n)
        else $error("memory selected while sleeping");

    read_done_a: assert property (@(posedge i_clk_sys) disable iff (!rstn_s)
        $fell(o_pins.oe_n) |-> ##6 o_rd_valid)
        else $error("read data not returned at access delay");

    write_len_a: assert property (@(posedge i_clk_sys) disable iff (!rstn_s)
        $fell(o_pins.we_n) |-> !o_pins.we_n [*2])
        else $error("write pulse shorter than needed");

    read_release_a: assert property (@(posedge i_clk_sys) disable iff (!rstn_s)
        o_rd_valid |-> $rose(o_pins.cs_n))
        else $error("read byte taken while memory still selected");
endmodule
`default_nettype wire

// >>> asrc_sram_model.sv
`timescale 1ns/1ps
`default_nettype none
// behavioural memory on the far side: no clock, it answers to pin levels only
module asrc_sram_model #(
    parameter int T_ACC = 25  // access delay in ns, raise it to model a slow part
) (
    input  wire logic                        i_cs_n,  // chip select, active low
    input  wire logic                        i_we_n,  // write enable, active low
    input  wire logic                        i_oe_n,  // output enable, active low
    input  wire logic [asrc_pkg::ADDR_W-1:0] i_addr,  // address
    input  wire logic [asrc_pkg::DATA_W-1:0] i_dq,    // resolved data wire
    output logic                             o_drive, // memory drives the wire
    output logic      [asrc_pkg::DATA_W-1:0] o_dq     // value offered on the wire
);
    logic [asrc_pkg::DATA_W-1:0]                   mem [0:32767];
    logic [asrc_pkg::DATA_W-1:0]                   rd_now;
    logic [asrc_pkg::ADDR_W+asrc_pkg::DATA_W:0]    late;
    logic [asrc_pkg::DATA_W-1:0]                   dq_late;

    // data seen 1 ns late: a bus release on the ending edge cannot leak into the store
    assign #1 dq_late = i_dq;

    // store follows the data while both strobes are low; the value before the end is kept
    always @* begin
        if (!i_cs_n && !i_we_n) begin
            mem[i_addr] = dq_late;
        end
    end

    // inertial copy: settles only once address, select and data held T_ACC
    assign rd_now = mem[i_addr];
    assign #(T_ACC) late = {i_addr, i_cs_n, rd_now};

    // drive only on read strobes; any write or deselect floats the pins at once
    assign o_drive = !i_cs_n && !i_oe_n && i_we_n;
    // before access time the pins show garbage, never an early right answer
    assign o_dq = (late === {i_addr, i_cs_n, rd_now}) ? rd_now : ~rd_now;
endmodule
`default_nettype wire

// >>> asrc_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module asrc_ctrl_tb;
    logic                 clk_sys = 1'b0;
    logic                 rstn = 1'b0;
    logic                 valid = 1'b0;
    logic                 wake = 1'b0;
    asrc_pkg::asrc_req_t  rq = '0;
    asrc_pkg::asrc_pins_t pins;
    logic [7:0]           c_dq, m_dq, wire_dq, rd_data;
    logic [7:0]           flt = 8'h5a;
    logic                 c_oe_n, m_drv, ready, rd_valid, sleeping;
    logic [14:0]          prev_addr = 15'h0000;
    logic                 prev_cs_n = 1'b1;
    logic [7:0]           ref_mem [logic [14:0]];
    logic [14:0]          used [$];
    int                   n_mismatch = 0;
    int                   checked = 0;

    always #12.5 clk_sys = ~clk_sys;
    // floating bus alternates between 5a and a6 every cycle so a stale byte cannot stay on the wire
    always @(posedge clk_sys) flt <= ~flt + 8'h01;
    assign wire_dq = !c_oe_n ? c_dq : (m_drv ? m_dq : flt);

    asrc_ctrl DUT (
        .i_clk_sys(clk_sys), .i_rstn(rstn), .i_req_valid(valid), .i_req(rq),
        .i_wake(wake), .i_dq(wire_dq), .o_req_ready(ready), .o_rd_valid(rd_valid),
        .o_rd_data(rd_data), .o_sleeping(sleeping), .o_pins(pins), .o_dq(c_dq),
        .o_dq_oe_n(c_oe_n)
    );
    asrc_sram_model u_mem (
        .i_cs_n(pins.cs_n), .i_we_n(pins.we_n), .i_oe_n(pins.oe_n),
        .i_addr(pins.addr), .i_dq(wire_dq), .o_drive(m_drv), .o_dq(m_dq)
    );

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // hold the request until the edge that finds ready high takes it
    task automatic req(input asrc_pkg::asrc_cmd_t c, input logic [14:0] a,
                       input logic [7:0] d);
        int n;
        n = 0;
        @(negedge clk_sys);
        valid = 1'b1;
        rq.cmd = c;
        rq.addr = a;
        rq.wdata = d;
        while (ready !== 1'b1 && n < 50) begin
            @(negedge clk_sys);
            n++;
        end
        chk("req ready", 16'h0001, {15'h0, ready});
        @(posedge clk_sys);
        @(negedge clk_sys);
        valid = 1'b0;
    endtask

    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        req(asrc_pkg::ASRC_CMD_WRITE, a, d);
        ref_mem[a] = d;
        used.push_back(a);
    endtask

    task automatic rd(input logic [14:0] a);
        int n;
        n = 0;
        req(asrc_pkg::ASRC_CMD_READ, a, 8'h00);
        while (rd_valid !== 1'b1 && n < 20) begin
            @(negedge clk_sys);
            n++;
        end
        chk("read byte", {8'h01, ref_mem[a]}, {7'h00, rd_valid, rd_data});
    endtask

    // pin watch every cycle out of reset
    always @(negedge clk_sys) begin
        if (rstn) begin
            if (!pins.oe_n) chk("we_n in read", 16'h0001, {15'h0, pins.we_n});
            if (!c_oe_n) begin
                chk("drive window", 16'h0000, {14'h0, pins.cs_n, pins.we_n});
            end
            if (!prev_cs_n && !pins.cs_n) begin
                chk("addr held", {1'b0, prev_addr}, {1'b0, pins.addr});
            end
            if (sleeping) chk("sleep deselect", 16'h0001, {15'h0, pins.cs_n});
        end
        prev_addr <= pins.addr;
        prev_cs_n <= pins.cs_n;
    end

    // watchdog: the whole run needs well under 5000 cycles
    initial begin
        #(25 * 5000);
        n_mismatch++;
        end_sim();
    end

    initial begin
        void'($urandom(32'h6eaadf98));
        repeat (2) @(negedge clk_sys);
        rstn = 1'b1;
        // lowest and highest location, then back-to-back write and read
        wr(15'h0000, 8'hff);
        wr(15'h7fff, 8'h00);
        rd(15'h7fff);
        rd(15'h0000);
        for (int i = 0; i < 40; i++) begin
            if ($urandom % 2) wr(15'($urandom), 8'($urandom));
            else rd(used[$urandom % used.size()]);
        end
        // retention: deselected while asleep, contents kept after wake
        req(asrc_pkg::ASRC_CMD_SLEEP, 15'h0000, 8'h00);
        repeat (5) @(negedge clk_sys);
        chk("sleeping", 16'h0001, {15'h0, sleeping});
        wake = 1'b1;
        repeat (4) @(negedge clk_sys);
        wake = 1'b0;
        chk("awake", 16'h0000, {15'h0, sleeping});
        rd(used[used.size()-1]);
        // reset in mid-read must deselect at once and keep stored data
        req(asrc_pkg::ASRC_CMD_READ, 15'h0000, 8'h00);
        rstn = 1'b0;
        @(negedge clk_sys);
        chk("reset pins", 16'h000f, {12'h0, pins.cs_n, pins.we_n, pins.oe_n, c_oe_n});
        rstn = 1'b1;
        rd(15'h7fff);
        end_sim();
    end
endmodule
`default_nettype wire
